/* File: tb.sv */
// Purpose: self-checking bench for the timer output compare block
// Assumes: tick pulses are made by the bench, one system clock wide
// Notes:   pwm counting is outside the block; only buffering is checked there
`timescale 1ns/1ps
module tb;
    import tmroc_pkg::*;
    logic       clk, reset_n, tick, reg_wr, reg_rd, ack_on;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] irq_req, irq_ack, lat;
    logic [2:0] port_value, pin_direction_bit, pin_out, pin_oe;
    int         err_total, tests_run, i;
    localparam logic [7:0] a_cma = TMROC_ADDR_CMP_L0;
    localparam logic [7:0] a_cmb = TMROC_ADDR_CMP_L0 + 8'h02;
    localparam logic [7:0] a_flg = TMROC_ADDR_FLAGS;
    localparam logic [7:0] a_cnt = TMROC_ADDR_CNT_L;
    localparam logic [7:0] a_oma = TMROC_ADDR_CTRL_A;
    localparam logic [7:0] a_gen = TMROC_ADDR_CTRL_B;
    localparam logic [7:0] a_frc = TMROC_ADDR_FORCE;
    logic [1:0] modes [4] = '{TMROC_COM_SET, TMROC_COM_CLEAR, TMROC_COM_TOGGLE, TMROC_COM_TOGGLE};
    logic       exps  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    tmroc_core i_tmroc_core (.clk(clk), .reset_n(reset_n), .tick(tick), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_req(irq_req), .irq_ack(irq_ack), .port_value(port_value),
        .pin_direction_bit(pin_direction_bit), .pin_out(pin_out), .pin_oe(pin_oe));
    tmroc_cpu_model i_tmroc_cpu_model (.clk(clk), .reset_n(reset_n), .ack_on(ack_on), .lat(lat),
        .irq_req(irq_req), .irq_ack(irq_ack));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // high byte first: the low write loads the whole value
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a + 8'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask : wr16

    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        chk(nm, {8'h00, exp}, {8'h00, reg_rdata});
    endtask : rchk

    task automatic tk(input int n);
        repeat (n)
        begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
    endtask : tk

    task automatic pchk(input int idx, input logic e);
        @(negedge clk);
        chk("pin_out", {15'h0, e}, {15'h0, pin_out[idx]});
    endtask : pchk

    initial
    begin
        {tick, reg_wr, reg_rd, ack_on, reset_n} = 5'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        lat = 4'h3;
        port_value = 3'b101;
        pin_direction_bit = 3'b110;
        err_total = 0;
        tests_run = 0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk("pin_out", 16'h0005, {13'h0, pin_out});
        chk("pin_oe", 16'h0006, {13'h0, pin_oe});
        rchk("flags", a_flg, 8'h00);
        rchk("unmapped", 8'h20, 8'h00);
        wr16(a_cma, 16'h1234);
        rchk("cmp_a_l", a_cma, 8'h34);
        rchk("cmp_a_h", a_cma + 8'h01, 8'h12);
        wr(a_cmb + 8'h01, 8'hAB);
        rchk("cmp_b_h", a_cmb + 8'h01, 8'h00);
        wr(a_cmb, 8'hCD);
        rchk("cmp_b_h", a_cmb + 8'h01, 8'hAB);
        // normal mode match, toggle on channel a
        wr16(a_cma, 16'h0012);
        wr(TMROC_ADDR_IRQ_EN, 8'h01);
        wr(a_oma, 8'h01);
        wr16(a_cnt, 16'h0010);
        tk(2);
        rchk("flags", a_flg, 8'h00);
        tk(1);
        rchk("flags", a_flg, 8'h01);
        chk("irq_req", 16'h0001, {12'h0, irq_req});
        pchk(0, 1'b1);
        rchk("cnt_l", a_cnt, 8'h13);
        wr(a_flg, 8'h01);
        rchk("flags", a_flg, 8'h00);
        chk("irq_req", 16'h0000, {12'h0, irq_req});
        // a counter write hides a match at the next tick, even with tick idle
        wr16(a_cmb, 16'h0020);
        wr16(a_cnt, 16'h0020);
        repeat (4) @(posedge clk);
        rchk("cnt_l", a_cnt, 8'h20);
        tk(1);
        rchk("flags", a_flg, 8'h00);
        rchk("cnt_l", a_cnt, 8'h21);
        // force strobe on channel c through every action
        for (i = 0; i < 4; i++)
        begin
            wr(a_oma, {2'b00, modes[i], 4'h0});
            wr(a_frc, 8'h04);
            pchk(2, exps[i]);
        end
        rchk("flags", a_flg, 8'h00);
        rchk("cnt_l", a_cnt, 8'h21);
        wr(a_oma, 8'h00);
        wr(a_frc, 8'h04);
        pchk(2, 1'b1);
        wr(a_oma, 8'h10);
        pchk(2, 1'b0);
        wr(a_frc, 8'h04);
        pchk(2, 1'b1);
        wr(a_gen, 8'h05);
        wr(a_gen, 8'h00);
        pchk(2, 1'b1);
        // overflow in normal mode
        wr(a_flg, 8'h0F);
        wr16(a_cnt, 16'hFFFF);
        tk(1);
        rchk("flags", a_flg, 8'h08);
        rchk("cnt_l", a_cnt, 8'h00);
        // clear on match with channel a, then with the capture register
        wr(a_oma, 8'h01);
        wr16(a_cma, 16'h0003);
        wr(a_gen, {4'h0, TMROC_WGM_CTC_CMP});
        wr16(a_cnt, 16'h0000);
        wr(a_flg, 8'h0F);
        tk(4);
        rchk("cnt_l", a_cnt, 8'h00);
        rchk("flags", a_flg, 8'h01);
        pchk(0, 1'b0);
        wr16(TMROC_ADDR_CAP_L, 16'h0002);
        wr(a_gen, {4'h0, TMROC_WGM_CTC_CAP});
        wr16(a_cnt, 16'h0000);
        tk(3);
        rchk("cnt_l", a_cnt, 8'h00);
        wr(a_gen, {4'h0, TMROC_WGM_CTC_CMP});
        wr(a_flg, 8'h0F);
        wr16(a_cnt, 16'hFFFF);
        tk(1);
        rchk("flags", a_flg, 8'h08);
        // pwm code: new compare value waits in the buffer
        wr(a_gen, 8'h00);
        wr16(a_cmb, 16'h0050);
        wr(a_gen, 8'h05);
        wr16(a_cmb, 16'h0060);
        rchk("cmp_b_l", a_cmb, 8'h60);
        wr16(a_cnt, 16'h004F);
        wr(a_flg, 8'h0F);
        tk(2);
        rchk("flags", a_flg, 8'h02);
        // interrupt serviced by the cpu model
        wr(a_gen, 8'h00);
        wr(a_flg, 8'h0F);
        wr16(a_cma, 16'h0005);
        wr16(a_cnt, 16'h0004);
        ack_on <= 1'b1;
        tk(2);
        for (i = 0; i < 20 && irq_ack[0] !== 1'b1; i++)
            @(negedge clk);
        chk("irq_ack", 16'h0001, {15'h0, irq_ack[0]});
        ack_on <= 1'b0;
        rchk("flags", a_flg, 8'h00);
        tally_and_finish();
    end
endmodule : tb

/* File: tmroc_channel.sv */
// Purpose: one compare channel: compare value, buffer, match and waveform output
// Assumes: byte writes arrive already merged with the staging byte
// Notes:   pwm waveforms are out of scope; in pwm modes the output holds
`timescale 1ns/1ps
module tmroc_channel
    import tmroc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // control
    input  wire logic        tick,
    input  wire logic        pwm_mode,
    input  wire logic        at_reload,
    input  wire logic        block_match,
    input  wire logic [1:0]  out_mode,
    input  wire logic        force_strobe,
    // cpu write of a full 16-bit value
    input  wire logic        value_wr,
    input  wire logic [15:0] value_wdata,
    // counter
    input  wire logic [15:0] count,
    // results
    output logic [15:0] value,
    output logic        match_raw,
    output logic        match_evt,
    output logic        wave
);
    typedef struct packed {
        logic [15:0] active;
        logic [15:0] buffer;
        logic        wave;
    } tmroc_ch_s;

    tmroc_ch_s st_r;
    tmroc_ch_s st_nxt;
    logic      act;

    assign match_raw = (count == st_r.active); // R1
    assign match_evt = tick && match_raw && !block_match; // R9 R24
    assign value     = pwm_mode ? st_r.buffer : st_r.active; // R5
    assign wave      = st_r.wave;

    always_comb
    begin
        st_nxt = st_r;
        act    = match_evt || (force_strobe && !pwm_mode); // R8
        // only the cpu path writes the compare value
        if (value_wr)
        begin
            if (pwm_mode)
                st_nxt.buffer = value_wdata; // R4 R5 R6
            else
                st_nxt.active = value_wdata; // R4 R5
        end
        if (pwm_mode && tick && at_reload && !(value_wr))
            st_nxt.active = st_r.buffer; // R4
        // mode field read live, so it acts on the very next match
        if (act && !pwm_mode) // R13 R16
        begin
            case (out_mode)
                TMROC_COM_OFF:    st_nxt.wave = st_r.wave; // R15
                TMROC_COM_TOGGLE: st_nxt.wave = ~st_r.wave; // R21
                TMROC_COM_CLEAR:  st_nxt.wave = 1'b0; // R23
                TMROC_COM_SET:    st_nxt.wave = 1'b1; // R23
                default:          st_nxt.wave = st_r.wave;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st_r <= '0; // R12
        else
            st_r <= st_nxt;
    end

    property p_wave_hold_off;
        @(posedge clk) disable iff (!reset_n)
        (out_mode == TMROC_COM_OFF) |=> (wave == $past(wave));
    endproperty
    a_wave_hold_off: assert property (p_wave_hold_off) else $error("wave changed with mode off"); // R15

    property p_toggle;
        @(posedge clk) disable iff (!reset_n)
        (match_evt && !pwm_mode && out_mode == TMROC_COM_TOGGLE) |=> (wave != $past(wave));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed"); // R21

    property p_set_clear;
        @(posedge clk) disable iff (!reset_n)
        (force_strobe && !pwm_mode && out_mode[1]) |=> (wave == $past(out_mode[0]));
    endproperty
    a_set_clear: assert property (p_set_clear) else $error("set or clear wrong"); // R8 R23

    property p_direct_write;
        @(posedge clk) disable iff (!reset_n)
        (value_wr && !pwm_mode) |=> (value == $past(value_wdata));
    endproperty
    a_direct_write: assert property (p_direct_write) else $error("direct write lost"); // R5

    // watch the stored words, not the view, which switches with the mode field
    property p_value_stable;
        @(posedge clk) disable iff (!reset_n)
        (!value_wr && !pwm_mode) |=> ($stable(st_r.active) && $stable(st_r.buffer));
    endproperty
    a_value_stable: assert property (p_value_stable) else $error("value changed without write"); // R6
endmodule : tmroc_channel

/* File: tmroc_core.sv */
// Purpose: 16-bit timer counter with output compare channels and pin override
// Assumes: tick is a one-cycle prescaled timer enable from the same clock
// Notes:   pwm counting is not built; pwm codes switch on buffering, hold the outputs and mask overflow
//
// Summary of operation
// R1: compare counter with each channel, flag next tick
// R2: interrupt while flag and enable; clear on ack/one
// R3: channel A may set counter ceiling
// R4: pwm modes buffer compare; update at ceiling (code updates at ceiling or at floor)
// R5: cpu reaches buffer or active compare register
// R6: only cpu changes compare; high byte reads direct
// R7: high byte staged, low write loads all
// R8: force strobe acts like match, no flag
// R9: counter write blocks matches next tick
// R10: software avoids writing counter onto ceiling
// R11: software sets output before pin direction
// R12: waveform output resets low, survives mode change
// R13: output mode unbuffered, acts on next match
// R14: nonzero output mode overrides port value
// R15: output mode zero leaves waveform unchanged
// R16: output mode selects set, clear, toggle
// R17: counting depends on generation mode only
// R18: normal mode counts up, wraps at max
// R19: normal mode overflow flag set at zero
// R20: clear-on-match clears at channel A or capture
// R21: output mode one toggles on match
// R22: clear-on-match overflow set at max wrap
// R23: output modes two, three clear and set
// R24: counting and matching only on tick
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module tmroc_core
    import tmroc_pkg::*;
#(
    parameter int NCH = TMROC_NCH
)
(
    // clock and reset
    input  wire logic           clk,
    input  wire logic           reset_n,
    // prescaled timer enable
    input  wire logic           tick,
    // register port
    input  wire logic [7:0]     reg_addr,
    input  wire logic [7:0]     reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output logic      [7:0]     reg_rdata,
    // interrupt handshake with the cpu core
    output logic      [NCH:0]   irq_req,
    input  wire logic [NCH:0]   irq_ack,
    // port pins
    input  wire logic [NCH-1:0] port_value,
    input  wire logic [NCH-1:0] pin_direction_bit,
    output logic      [NCH-1:0] pin_out,
    output logic      [NCH-1:0] pin_oe
);
    typedef struct packed {
        logic [15:0]    counter_value;
        logic [15:0]    capture_register;
        logic [7:0]     staging;
        logic [3:0]     waveform_generation_mode;
        logic [5:0]     compare_output_mode;
        logic [NCH:0]   irq_enable;
        logic [NCH:0]   flags;
        logic           wr_block;
        logic [7:0]     rdata;
    } tmroc_core_s;

    tmroc_core_s       st_r;
    tmroc_core_s       st_nxt;
    logic              pwm_mode;
    logic              ctc_mode;
    logic              at_reload;
    logic              cnt_wr;
    logic              ovf_evt;
    logic [15:0]       ceiling;
    logic [15:0]       cnt_inc;
    logic [NCH-1:0]    force_vec;
    logic [NCH-1:0]    value_wr;
    logic [15:0]       value     [NCH];
    logic [NCH-1:0]    match_raw;
    logic [NCH-1:0]    match_evt;
    logic [NCH-1:0]    wave;
    logic [15:0]       wr_word;

    assign ctc_mode = (st_r.waveform_generation_mode == TMROC_WGM_CTC_CMP)
                   || (st_r.waveform_generation_mode == TMROC_WGM_CTC_CAP);
    assign pwm_mode = !ctc_mode && (st_r.waveform_generation_mode != TMROC_WGM_NORMAL); // R4
    assign ceiling  = (st_r.waveform_generation_mode == TMROC_WGM_CTC_CAP)
                    ? st_r.capture_register : value[0]; // R3 R20
    assign at_reload = (st_r.counter_value == ceiling) || (st_r.counter_value == TMROC_FLOOR); // R4
    assign cnt_wr   = reg_wr && (reg_addr == TMROC_ADDR_CNT_L);
    assign cnt_inc  = st_r.counter_value + 16'h0001;
    assign wr_word  = {st_r.staging, reg_wdata}; // R7
    assign force_vec = (reg_wr && reg_addr == TMROC_ADDR_FORCE) ? reg_wdata[NCH-1:0] : '0; // R8
    assign irq_req  = st_r.flags & st_r.irq_enable; // R2
    assign reg_rdata = st_r.rdata;

    // mode field picks the next count and gates the overflow flag and, in pwm codes, the output actions
    assign ovf_evt = tick && (st_r.counter_value == TMROC_MAX) && !pwm_mode; // R19 R22

    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            assign value_wr[g] = reg_wr && (reg_addr == TMROC_ADDR_CMP_L0 + 8'(2 * g)); // R7
            // override the port only while the mode field is nonzero
            assign pin_out[g] = (st_r.compare_output_mode[2*g +: 2] != TMROC_COM_OFF)
                              ? wave[g] : port_value[g]; // R14
            assign pin_oe[g]  = pin_direction_bit[g]; // R14
            tmroc_channel u_ch
            (
                .clk          (clk),
                .reset_n      (reset_n),
                .tick         (tick),
                .pwm_mode     (pwm_mode),
                .at_reload    (at_reload),
                .block_match  (st_r.wr_block),
                .out_mode     (st_r.compare_output_mode[2*g +: 2]),
                .force_strobe (force_vec[g]),
                .value_wr     (value_wr[g]),
                .value_wdata  (wr_word),
                .count        (st_r.counter_value),
                .value        (value[g]),
                .match_raw    (match_raw[g]),
                .match_evt    (match_evt[g]),
                .wave         (wave[g])
            );
        end
    endgenerate

    always_comb
    begin
        st_nxt = st_r;
        // block stays armed until a tick consumes it, so a stopped timer keeps it
        if (tick)
            st_nxt.wr_block = 1'b0;
        if (cnt_wr)
            st_nxt.wr_block = 1'b1; // R9
        // counting
        if (tick)
        begin
            if (ctc_mode && (st_r.counter_value == ceiling) && !st_r.wr_block)
                st_nxt.counter_value = TMROC_FLOOR; // R20
            else
                st_nxt.counter_value = cnt_inc; // R18 R17 R24
        end
        // cpu register writes
        if (reg_wr)
        begin
            case (reg_addr)
                TMROC_ADDR_CNT_H,
                TMROC_ADDR_CAP_H:   st_nxt.staging = reg_wdata; // R7
                TMROC_ADDR_CNT_L:   st_nxt.counter_value = wr_word;
                TMROC_ADDR_CAP_L:   st_nxt.capture_register = wr_word;
                TMROC_ADDR_CTRL_A:  st_nxt.compare_output_mode = reg_wdata[5:0]; // R13
                TMROC_ADDR_CTRL_B:  st_nxt.waveform_generation_mode = reg_wdata[3:0];
                TMROC_ADDR_IRQ_EN:  st_nxt.irq_enable = reg_wdata[NCH:0];
                default:
                begin
                    if (reg_addr[0] && reg_addr >= TMROC_ADDR_CMP_H0 && reg_addr < TMROC_ADDR_CTRL_A)
                        st_nxt.staging = reg_wdata; // R7
                end
            endcase
        end
        // flags: clear by ack or write-one, then set wins
        st_nxt.flags = st_r.flags & ~irq_ack; // R2
        if (reg_wr && reg_addr == TMROC_ADDR_FLAGS)
            st_nxt.flags = st_nxt.flags & ~reg_wdata[NCH:0]; // R2
        st_nxt.flags[NCH-1:0] = st_nxt.flags[NCH-1:0] | match_evt; // R1
        if (ovf_evt)
            st_nxt.flags[TMROC_FLAG_OVF_BIT] = 1'b1; // R19 R22
        // read data one cycle after the strobe
        st_nxt.rdata = TMROC_RST_BYTE;
        if (reg_rd)
        begin
            case (reg_addr)
                TMROC_ADDR_CNT_L:   st_nxt.rdata = st_r.counter_value[7:0];
                TMROC_ADDR_CNT_H:   st_nxt.rdata = st_r.counter_value[15:8];
                TMROC_ADDR_CAP_L:   st_nxt.rdata = st_r.capture_register[7:0];
                TMROC_ADDR_CAP_H:   st_nxt.rdata = st_r.capture_register[15:8];
                TMROC_ADDR_CTRL_A:  st_nxt.rdata = {2'h0, st_r.compare_output_mode};
                TMROC_ADDR_CTRL_B:  st_nxt.rdata = {4'h0, st_r.waveform_generation_mode};
                TMROC_ADDR_IRQ_EN:  st_nxt.rdata = 8'({st_r.irq_enable});
                TMROC_ADDR_FLAGS:   st_nxt.rdata = 8'({st_r.flags});
                default:
                begin
                    for (int i = 0; i < NCH; i++)
                    begin
                        if (reg_addr == TMROC_ADDR_CMP_L0 + 8'(2 * i))
                            st_nxt.rdata = value[i][7:0];
                        if (reg_addr == TMROC_ADDR_CMP_H0 + 8'(2 * i))
                            st_nxt.rdata = value[i][15:8]; // R6
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    property p_flag_on_match;
        @(posedge clk) disable iff (!reset_n)
        (match_evt[0]) |=> st_r.flags[0];
    endproperty
    a_flag_on_match: assert property (p_flag_on_match) else $error("match flag not set"); // R1

    // a blocked tick with no force must leave every waveform output alone
    property p_blocked;
        @(posedge clk) disable iff (!reset_n)
        (st_r.wr_block && tick && (force_vec == '0)) |=> (wave == $past(wave));
    endproperty
    a_blocked: assert property (p_blocked) else $error("match after counter write"); // R9

    property p_no_tick_hold;
        @(posedge clk) disable iff (!reset_n)
        (!tick && !cnt_wr) |=> $stable(st_r.counter_value);
    endproperty
    a_no_tick_hold: assert property (p_no_tick_hold) else $error("counter moved without tick"); // R24

    property p_normal_wrap;
        @(posedge clk) disable iff (!reset_n)
        (tick && !cnt_wr && st_r.waveform_generation_mode == TMROC_WGM_NORMAL && st_r.counter_value == TMROC_MAX)
        |=> (st_r.counter_value == TMROC_FLOOR) && st_r.flags[TMROC_FLAG_OVF_BIT];
    endproperty
    a_normal_wrap: assert property (p_normal_wrap) else $error("wrap or overflow wrong"); // R18 R19

    property p_ctc_clear;
        @(posedge clk) disable iff (!reset_n)
        (tick && !cnt_wr && ctc_mode && !st_r.wr_block && st_r.counter_value == ceiling)
        |=> (st_r.counter_value == TMROC_FLOOR);
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("clear-on-match missed"); // R20

    property p_irq;
        @(posedge clk) disable iff (!reset_n)
        (st_r.flags[0] && st_r.irq_enable[0]) |-> irq_req[0];
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not requested"); // R2

    property p_override;
        @(posedge clk) disable iff (!reset_n)
        (st_r.compare_output_mode[1:0] == TMROC_COM_OFF) |-> (pin_out[0] == port_value[0]);
    endproperty
    a_override: assert property (p_override) else $error("port override wrong"); // R14

    property p_force_noflag;
        @(posedge clk) disable iff (!reset_n)
        (force_vec[0] && !match_evt[0] && !st_r.flags[0]) |=> !st_r.flags[0];
    endproperty
    a_force_noflag: assert property (p_force_noflag) else $error("force set the flag"); // R8
endmodule : tmroc_core

/* File: tmroc_cpu_model.sv */
// Purpose: cpu core model that services compare and overflow interrupts
// Assumes: one acknowledge pulse per serviced request, lowest bit first
// Notes:   lat sets the response delay, so the core answers prompt or slow
`timescale 1ns/1ps
module tmroc_cpu_model
#(
    parameter int W = 4
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // service control from the bench
    input  wire logic         ack_on,
    input  wire logic [3:0]   lat,
    // interrupt handshake
    input  wire logic [W-1:0] irq_req,
    output logic      [W-1:0] irq_ack
);
    logic [3:0] wait_r;
    // no ack while the last one is still out, else a stale level is acked twice
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_ack <= '0;
            wait_r  <= 4'h0;
        end
        else
        begin
            irq_ack <= '0;
            wait_r  <= 4'h0;
            if (ack_on && (irq_req != '0) && (irq_ack == '0))
            begin
                if (wait_r >= lat)
                    irq_ack <= irq_req & (~irq_req + 1'b1);
                else
                    wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule : tmroc_cpu_model

/* File: tmroc_pkg.sv */
// Purpose: shared constants for the 16-bit timer output compare block
// Assumes: byte-wide register port, one aligned address per byte register
// Notes:   offsets are byte indices on the plain register port
package tmroc_pkg;
    localparam int          TMROC_NCH          = 3;
    localparam logic [7:0]  TMROC_ADDR_CNT_L   = 8'h00;
    localparam logic [7:0]  TMROC_ADDR_CNT_H   = 8'h01;
    localparam logic [7:0]  TMROC_ADDR_CAP_L   = 8'h02;
    localparam logic [7:0]  TMROC_ADDR_CAP_H   = 8'h03;
    localparam logic [7:0]  TMROC_ADDR_CMP_L0  = 8'h04;
    localparam logic [7:0]  TMROC_ADDR_CMP_H0  = 8'h05;
    localparam logic [7:0]  TMROC_ADDR_CTRL_A  = 8'h0A;
    localparam logic [7:0]  TMROC_ADDR_CTRL_B  = 8'h0B;
    localparam logic [7:0]  TMROC_ADDR_FORCE   = 8'h0C;
    localparam logic [7:0]  TMROC_ADDR_IRQ_EN  = 8'h0D;
    localparam logic [7:0]  TMROC_ADDR_FLAGS   = 8'h0E;
    localparam logic [7:0]  TMROC_ADDR_INT_ACK = 8'h0F;
    localparam int          TMROC_FLAG_OVF_BIT = 3;
    localparam logic [3:0]  TMROC_WGM_NORMAL   = 4'h0;
    localparam logic [3:0]  TMROC_WGM_CTC_CMP  = 4'h4;
    localparam logic [3:0]  TMROC_WGM_CTC_CAP  = 4'hC;
    localparam logic [15:0] TMROC_MAX          = 16'hFFFF;
    localparam logic [15:0] TMROC_FLOOR        = 16'h0000;
    localparam logic [7:0]  TMROC_RST_BYTE     = 8'h00;
    localparam logic [1:0]  TMROC_COM_OFF      = 2'h0;
    localparam logic [1:0]  TMROC_COM_TOGGLE   = 2'h1;
    localparam logic [1:0]  TMROC_COM_CLEAR    = 2'h2;
    localparam logic [1:0]  TMROC_COM_SET      = 2'h3;
endpackage : tmroc_pkg
